// ### break_cycle_control.sv
// break-cycle arbitration and T1..T7 sequencing for the central processor
// Function
// RULE_01: break considered only at instruction done
// RULE_02: priority data, then clock, then program
// RULE_03: data requester presents address, data, direction
// RULE_04: data break clears instruction, loads address
// RULE_05: outward transfer reads word between T2-T3
// RULE_06: inward transfer gates device data at T3
// RULE_07: after data break fetch or next break
// RULE_08: clock enabled by io-transfer; pulses request
// RULE_09: clock break increments location seven
// RULE_10: count overflow sets clock flag
// RULE_11: program break needs enable, no others
// RULE_12: program break clears buffer, discards location zero
// RULE_13: T3 stores link, extend, trap, counter
// RULE_14: T4 counter from address, write zero
// RULE_15: T5 counter to one, enable cleared
// RULE_16: trapped break steps counter to two
// RULE_17: program break ends in fetch or break
// RULE_18: data and clock breaks ignore enable
// RULE_19: trap mode needs switch and trap-on
// RULE_20: trapped instruction sets flag, suppressed, requests
// RULE_21: io-transfer device pulses and accumulator clear
// RULE_22: reset clears enables, flags, pending requests
//
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module break_cycle_control
  import break_cycle_pkg::*;
#(
  parameter int AW = break_cycle_pkg::ADDR_W,
  parameter int DW = break_cycle_pkg::WORD_W
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  // processor timing and instruction status
  input  wire logic          instrDone,
  input  wire logic          ioTransferInstruction,
  input  wire logic          haltInstruction,
  input  wire logic          executeInstruction,
  input  wire logic          ioStepT1,
  input  wire logic          ioStepT5,
  input  wire logic          ioStepT7,
  input  wire logic [DW-1:0] instructionWord,
  input  wire logic [2:0]    ioSubCommand,
  input  wire logic          trapSwitch,
  input  wire logic          linkBit,
  input  wire logic          extendMode,
  input  wire logic [AW-1:0] programCounterIn,
  // fast peripheral data break
  input  wire logic          dataReq,
  input  wire logic          dataInward,
  input  wire logic [AW-1:0] dataAddr,
  input  wire logic [DW-1:0] dataOut,
  // slow peripheral flags and clock
  input  wire logic          deviceFlagAny,
  input  wire logic          clockPulse,
  // memory
  input  wire logic [DW-1:0] memReadData,
  // processor register controls
  output logic               clearInstrReg_q,
  output logic [AW-1:0]      memoryAddressReg_q,
  output logic [DW-1:0]      memoryBuffer_q,
  output logic               memRead_q,
  output logic               memWrite_q,
  output logic               bufferValid_q,
  output logic [AW-1:0]      programCounter_q,
  output logic               pcLoad_q,
  output logic               fetchState_q,
  output logic               breakActive_q,
  output logic               suppressInstr_q,
  output logic               clearAcc_q,
  // device pulses and status
  output logic               devicePulseOne_q,
  output logic               devicePulseTwo_q,
  output logic               devicePulseFour_q,
  output logic               interruptEnable_q,
  output logic               trapFlag_q,
  output logic               trapMode_q,
  output logic               clockEnable_q,
  output logic               clockFlag_q
);
  import break_cycle_pkg::*;

  step_t      step_q;
  brk_t       kind_q;
  logic       clockReq_q;
  logic       trapArm_q;
  logic       pulseFourPend_q;
  logic       illegal;
  logic       dataPend;
  logic       clockPend;
  logic       pgmPend;
  logic       grantAny;

  assign illegal = trapMode_q && instrDone &&
    (ioTransferInstruction || haltInstruction || executeInstruction); // RULE_19
  assign dataPend  = dataReq; // RULE_03
  assign clockPend = clockReq_q;
  assign pgmPend   = interruptEnable_q && (deviceFlagAny || clockFlag_q ||
                     trapFlag_q) && !(kind_q == BK_PGM); // RULE_11
  assign grantAny  = dataPend || clockPend || pgmPend; // RULE_18

  // break sequencer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      step_q <= ST_IDLE;
      kind_q <= BK_NONE;
    end else begin
      case (step_q)
        ST_IDLE: begin
          if (instrDone && !illegal && grantAny) begin // RULE_01
            step_q <= ST_T1;
            if (dataPend) begin // RULE_02
              kind_q <= BK_DATA;
            end else if (clockPend) begin
              kind_q <= BK_CLOCK;
            end else begin
              kind_q <= BK_PGM;
            end
          end
        end
        ST_T1: step_q <= ST_T2;
        ST_T2: step_q <= ST_T3;
        ST_T3: step_q <= ST_T4;
        ST_T4: step_q <= ST_T5;
        ST_T5: step_q <= ST_T6;
        ST_T6: step_q <= ST_T7;
        ST_T7: begin
          // a preceding break is itself an instruction-done point
          if (dataPend || clockPend ||
              (pgmPend && kind_q != BK_PGM)) begin // RULE_07 RULE_17
            step_q <= ST_T1;
            if (dataPend) begin
              kind_q <= BK_DATA;
            end else if (clockPend) begin
              kind_q <= BK_CLOCK;
            end else begin
              kind_q <= BK_PGM;
            end
          end else begin
            step_q <= ST_IDLE;
            kind_q <= BK_NONE;
          end
        end
        default: begin
          step_q <= ST_IDLE;
          kind_q <= BK_NONE;
        end
      endcase
    end
  end

  // processor register steering during a break
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clearInstrReg_q    <= 1'b0;
      memoryAddressReg_q <= ADDR_ZERO;
      memoryBuffer_q     <= WORD_ZERO;
      memRead_q          <= 1'b0;
      memWrite_q         <= 1'b0;
      bufferValid_q      <= 1'b0;
      programCounter_q   <= ADDR_ZERO;
      pcLoad_q           <= 1'b0;
      fetchState_q       <= 1'b1;
      breakActive_q      <= 1'b0;
    end else begin
      clearInstrReg_q <= 1'b0;
      memRead_q       <= 1'b0;
      memWrite_q      <= 1'b0;
      bufferValid_q   <= 1'b0;
      pcLoad_q        <= 1'b0;
      breakActive_q   <= (step_q != ST_IDLE);
      case (step_q)
        ST_IDLE: begin
          fetchState_q <= 1'b1;
          if (instrDone && !illegal && grantAny) begin
            fetchState_q <= 1'b0;
          end
        end
        ST_T1: begin
          clearInstrReg_q <= 1'b1; // RULE_04 RULE_09 RULE_12
          if (kind_q == BK_DATA) begin
            memoryAddressReg_q <= dataAddr; // RULE_04
          end else if (kind_q == BK_CLOCK) begin
            memoryAddressReg_q <= CLOCK_ADDR; // RULE_09
          end else begin
            memoryAddressReg_q <= PGM_ADDR; // RULE_14
          end
        end
        ST_T2: begin
          memRead_q <= 1'b1;
          if (kind_q == BK_PGM) begin
            memoryBuffer_q <= WORD_ZERO; // RULE_12
          end
        end
        ST_T3: begin
          case (kind_q)
            BK_DATA: begin
              if (dataInward) begin
                memoryBuffer_q <= dataOut; // RULE_06
              end else begin
                memoryBuffer_q <= memReadData; // RULE_05
                bufferValid_q  <= 1'b1;
              end
            end
            BK_CLOCK: memoryBuffer_q <= memReadData + WORD_ONE; // RULE_09
            BK_PGM: begin
              memoryBuffer_q <= {programCounter_q, 3'h0}; // RULE_13
              memoryBuffer_q[BUF_LINK_BIT] <= linkBit;
              memoryBuffer_q[BUF_EXT_BIT]  <= extendMode;
              memoryBuffer_q[BUF_TRAP_BIT] <= trapFlag_q;
              programCounter_q <= ADDR_ZERO;
            end
            default: memoryBuffer_q <= memoryBuffer_q;
          endcase
        end
        ST_T4: begin
          if (kind_q == BK_DATA) begin
            memWrite_q <= dataInward; // RULE_06
            bufferValid_q <= !dataInward;
          end else begin
            memWrite_q <= 1'b1; // RULE_09 RULE_14
          end
          if (kind_q == BK_PGM) begin
            programCounter_q <= memoryAddressReg_q; // RULE_14
          end
        end
        ST_T5: begin
          if (kind_q == BK_PGM) begin
            pcLoad_q <= 1'b1;
            programCounter_q <= trapFlag_q ?
              programCounter_q + PGM_STEP + PGM_STEP : // RULE_16
              programCounter_q + PGM_STEP; // RULE_15
          end
        end
        ST_T6: begin
          pcLoad_q <= (kind_q == BK_PGM);
        end
        ST_T7: begin
          memoryAddressReg_q <= ADDR_ZERO;
          fetchState_q <= !(dataPend || clockPend ||
                          (pgmPend && kind_q != BK_PGM)); // RULE_07 RULE_17
        end
        default: fetchState_q <= 1'b1;
      endcase
      if (step_q == ST_IDLE) begin
        programCounter_q <= programCounterIn;
      end
    end
  end

  // clock enable, clock request and clock flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clockEnable_q <= 1'b0;
      clockReq_q    <= 1'b0;
      clockFlag_q   <= 1'b0;
    end else begin
      if (ioTransferInstruction && ioStepT5 && !trapMode_q) begin
        if (ioSubCommand == IOT_CLK_ON) begin
          clockEnable_q <= 1'b1; // RULE_08
        end else if (ioSubCommand == IOT_CLK_OFF) begin
          clockEnable_q <= 1'b0;
        end
      end
      if (step_q == ST_T1 && kind_q == BK_CLOCK) begin
        clockReq_q <= 1'b0; // RULE_09
      end
      if (clockEnable_q && clockPulse) begin
        clockReq_q <= 1'b1; // RULE_08
      end
      if (step_q == ST_T3 && kind_q == BK_CLOCK && memReadData == {DW{1'b1}}) begin
        clockFlag_q <= 1'b1; // RULE_10
      end else if (step_q == ST_T5 && kind_q == BK_PGM) begin
        clockFlag_q <= 1'b0;
      end
    end
  end

  // interrupt enable, trap mode and trap flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      interruptEnable_q <= 1'b0;
      trapArm_q         <= 1'b0;
      trapMode_q        <= 1'b0;
      trapFlag_q        <= 1'b0;
      suppressInstr_q   <= 1'b0;
    end else begin
      suppressInstr_q <= illegal; // RULE_20
      trapMode_q      <= trapSwitch && trapArm_q; // RULE_19
      if (ioTransferInstruction && ioStepT5 && !trapMode_q) begin
        if (ioSubCommand == IOT_TRAP_ON) begin
          trapArm_q <= 1'b1;
        end
        if (ioSubCommand == IOT_INT_ON) begin
          interruptEnable_q <= 1'b1;
        end else if (ioSubCommand == IOT_INT_OFF) begin
          interruptEnable_q <= 1'b0;
        end
      end
      if (step_q == ST_T5 && kind_q == BK_PGM) begin
        interruptEnable_q <= 1'b0; // RULE_15
        trapFlag_q <= 1'b0;
      end
      if (illegal) begin
        trapFlag_q <= 1'b1; // RULE_20
      end
    end
  end

  // io-transfer device pulses and accumulator clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      devicePulseOne_q  <= 1'b0;
      devicePulseTwo_q  <= 1'b0;
      devicePulseFour_q <= 1'b0;
      pulseFourPend_q   <= 1'b0;
      clearAcc_q        <= 1'b0;
    end else begin
      devicePulseOne_q  <= 1'b0;
      devicePulseTwo_q  <= 1'b0;
      devicePulseFour_q <= 1'b0;
      clearAcc_q        <= 1'b0;
      if (ioTransferInstruction && !trapMode_q) begin
        if (ioStepT5) begin
          clearAcc_q       <= instructionWord[IOT_CLR_AC_BIT]; // RULE_21
          devicePulseOne_q <= instructionWord[IOT_P1_BIT]; // RULE_21
        end
        if (ioStepT7) begin
          devicePulseTwo_q <= instructionWord[IOT_P2_BIT]; // RULE_21
          pulseFourPend_q  <= instructionWord[IOT_P4_BIT];
        end
      end
      if (ioStepT1 && pulseFourPend_q) begin
        devicePulseFour_q <= 1'b1; // RULE_21
        pulseFourPend_q   <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### break_cycle_control_tb.sv
// self-checking bench for the break-cycle control
`timescale 1ns/1ns
`default_nettype none
module break_cycle_control_tb;
  import break_cycle_pkg::*;
  logic clk_sys, sys_rst, instrDone, ioTransferInstruction, haltInstruction;
  logic executeInstruction, ioStepT1, ioStepT5, ioStepT7, trapSwitch;
  logic linkBit, extendMode, dataReq, dataInward, deviceFlagAny, clockPulse;
  logic devGo, devIn, clearInstrReg_q, memRead_q, memWrite_q, bufferValid_q;
  logic pcLoad_q, fetchState_q, breakActive_q, suppressInstr_q, clearAcc_q;
  logic devicePulseOne_q, devicePulseTwo_q, devicePulseFour_q, clockFlag_q;
  logic interruptEnable_q, trapFlag_q, trapMode_q, clockEnable_q;
  logic [17:0] instructionWord, dataOut, memReadData, memoryBuffer_q;
  logic [17:0] got, devWord;
  logic [14:0] programCounterIn, dataAddr, memoryAddressReg_q;
  logic [14:0] programCounter_q, devAddr;
  logic [2:0]  ioSubCommand;
  logic [14:0] maQ[$];
  logic [17:0] bufQ[$];
  int          n_fail;
  int          checked;
  int          cyc;

  break_cycle_control dut (.*);
  periph_model dev (.*);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // address of every break and word of every write
  always @(posedge clk_sys) begin
    if (clearInstrReg_q === 1'b1) maQ.push_back(memoryAddressReg_q);
    if (memWrite_q === 1'b1) bufQ.push_back(memoryBuffer_q);
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 4000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [17:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one io-transfer with its T5, T7 and following T1 steps
  task automatic io_transfer_instruction(input logic [2:0] cmd, input logic [17:0] w);
    @(posedge clk_sys);
    {ioTransferInstruction, ioStepT5, ioSubCommand, instructionWord} <=
      {2'b11, cmd, w};
    @(posedge clk_sys);
    {ioStepT5, ioStepT7} <= 2'b01;
    #1;
    chk("clracc", clearAcc_q, w[IOT_CLR_AC_BIT]);
    chk("pulse1", devicePulseOne_q, w[IOT_P1_BIT]);
    @(posedge clk_sys);
    {ioTransferInstruction, ioStepT7, ioStepT1} <= 3'b001;
    #1;
    chk("pulse2", devicePulseTwo_q, w[IOT_P2_BIT]);
    @(posedge clk_sys);
    ioStepT1 <= 1'b0;
    #1;
    chk("pulse4", devicePulseFour_q, w[IOT_P4_BIT]);
  endtask
  // one instruction-done point, then wait for the fetch state
  task automatic brk;
    maQ.delete();
    bufQ.delete();
    @(posedge clk_sys);
    instrDone <= 1'b1;
    @(posedge clk_sys);
    instrDone <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 80; i++) begin
      @(posedge clk_sys);
      #1;
      if (fetchState_q === 1'b1) break;
    end
    chk("fetch", fetchState_q, 1);
  endtask
  task automatic t_data(input logic inw, input logic [14:0] a,
                        input logic [17:0] w);
    @(posedge clk_sys);
    {devGo, devIn, devAddr, devWord} <= {1'b1, inw, a, w};
    @(posedge clk_sys);
    devGo <= 1'b0;
    brk();
    chk("addr", maQ[0], a);
    chk("word", inw ? bufQ[0] : got, inw ? w : memReadData);
    chk("count", 18'(maQ.size()), 1);
  endtask
  task automatic t_prio;
    @(posedge clk_sys);
    {memReadData, deviceFlagAny, clockPulse} <= {18'h00005, 2'b11};
    {devGo, devIn, devAddr} <= {2'b10, 15'h0100};
    @(posedge clk_sys);
    {clockPulse, devGo} <= 2'b00;
    brk();
    chk("ma0", maQ[0], 15'h0100);
    chk("ma1", maQ[1], CLOCK_ADDR);
    chk("ma2", maQ[2], PGM_ADDR);
    chk("tick", bufQ[0], 18'h00006);
    chk("save", bufQ[1], {programCounterIn, 3'b011});
    chk("pc", programCounter_q, PGM_STEP);
    chk("ie", interruptEnable_q, 0);
    brk();
    chk("held", 18'(maQ.size()), 0);
    t_data(1'b1, 15'h0042, 18'h3FFFE);
  endtask
  task automatic t_ovf;
    @(posedge clk_sys);
    {memReadData, deviceFlagAny, clockPulse} <= {18'h3FFFF, 2'b01};
    @(posedge clk_sys);
    clockPulse <= 1'b0;
    brk();
    chk("wrap", bufQ[0], WORD_ZERO);
    chk("cflag", clockFlag_q, 1);
    io_transfer_instruction(IOT_CLK_OFF, WORD_ZERO);
    chk("cen", clockEnable_q, 0);
  endtask
  task automatic t_trap;
    io_transfer_instruction(IOT_TRAP_ON, WORD_ZERO);
    chk("tm0", trapMode_q, 0);
    io_transfer_instruction(IOT_INT_ON, WORD_ZERO);
    trapSwitch <= 1'b1;
    io_transfer_instruction(IOT_TRAP_ON, WORD_ZERO);
    chk("tm1", {trapMode_q, interruptEnable_q}, 3);
    @(posedge clk_sys);
    {haltInstruction, instrDone} <= 2'b11;
    @(posedge clk_sys);
    {haltInstruction, instrDone} <= 2'b00;
    #1;
    chk("trap", {trapFlag_q, suppressInstr_q}, 3);
    brk();
    chk("pc2", programCounter_q, 15'h0002);
    chk("tsave", bufQ[0][2], 1);
  endtask

  initial begin
    {instrDone, ioTransferInstruction, haltInstruction, executeInstruction} = '0;
    {ioStepT1, ioStepT5, ioStepT7, trapSwitch, deviceFlagAny} = '0;
    {clockPulse, devGo, devIn, devAddr, devWord, ioSubCommand} = '0;
    {instructionWord, memReadData} = {18'h0, 18'h2A5A5};
    {linkBit, extendMode, programCounterIn} = {2'b11, 15'h1234};
    sys_rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("rstfetch", fetchState_q, 1);
    chk("rstflags", {interruptEnable_q, trapFlag_q, trapMode_q,
        clockEnable_q, clockFlag_q}, 0);
    io_transfer_instruction(3'h0, 18'h3C000);
    io_transfer_instruction(3'h0, WORD_ZERO);
    io_transfer_instruction(IOT_INT_ON, WORD_ZERO);
    io_transfer_instruction(IOT_CLK_ON, WORD_ZERO);
    chk("en", {interruptEnable_q, clockEnable_q}, 3);
    t_data(1'b0, 15'h1234, WORD_ZERO);
    t_data(1'b1, 15'h7FFF, 18'h15A5A);
    t_prio();
    t_ovf();
    t_trap();
    end_sim();
  end
endmodule
bind break_cycle_control break_cycle_monitor mon (.*);
`default_nettype wire

// ### break_cycle_monitor.sv
// concurrent checks on the break-cycle control ports
`timescale 1ns/1ns
`default_nettype none
module break_cycle_monitor
  import break_cycle_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // stimulus
  input wire logic        instrDone,
  input wire logic        ioTransferInstruction,
  input wire logic        haltInstruction,
  input wire logic        executeInstruction,
  input wire logic        ioStepT5,
  input wire logic [17:0] instructionWord,
  input wire logic        trapSwitch,
  input wire logic        dataReq,
  input wire logic        dataInward,
  input wire logic [14:0] dataAddr,
  input wire logic [17:0] dataOut,
  input wire logic [17:0] memReadData,
  // design outputs
  input wire logic        clearInstrReg_q,
  input wire logic [14:0] memoryAddressReg_q,
  input wire logic [17:0] memoryBuffer_q,
  input wire logic        memRead_q,
  input wire logic        memWrite_q,
  input wire logic        bufferValid_q,
  input wire logic [14:0] programCounter_q,
  input wire logic        fetchState_q,
  input wire logic        breakActive_q,
  input wire logic        suppressInstr_q,
  input wire logic        devicePulseOne_q,
  input wire logic        interruptEnable_q,
  input wire logic        trapFlag_q,
  input wire logic        trapMode_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // data break taken at an idle instruction-done point
  sequence s_grant;
    !breakActive_q && fetchState_q && instrDone && dataReq && !trapMode_q;
  endsequence
  a_data_addr: assert property (s_grant |-> ##2 clearInstrReg_q
    && memoryAddressReg_q == $past(dataAddr, 2))
    else $error("data break address not loaded");
  a_out_read: assert property (s_grant ##0 !dataInward
    |-> ##3 memRead_q ##1 bufferValid_q && memoryBuffer_q == memReadData)
    else $error("outward word not read");
  a_in_gate: assert property (s_grant ##0 dataInward |-> ##4
    !bufferValid_q && memoryBuffer_q == $past(dataOut, 4) ##1 memWrite_q)
    else $error("inward word not gated");
  a_pgm_vector: assert property ($fell(interruptEnable_q)
    && breakActive_q |-> ##2
    programCounter_q == ($past(trapFlag_q, 3) ? 15'h0002 : 15'h0001))
    else $error("service vector wrong");
  a_pulse_one: assert property (ioTransferInstruction && ioStepT5
    && instructionWord[IOT_P1_BIT] && !trapMode_q |=> devicePulseOne_q)
    else $error("device pulse one missing");
  a_trap_set: assert property (trapMode_q && instrDone && (ioTransferInstruction
    || haltInstruction || executeInstruction)
    |=> trapFlag_q && suppressInstr_q)
    else $error("illegal instruction not trapped");
  a_trap_mode: assert property ($rose(trapMode_q) |-> $past(trapSwitch))
    else $error("trap mode without switch");
  a_reset_vals: assert property (disable iff (1'b0) sys_rst |=>
    fetchState_q && !interruptEnable_q && !trapMode_q && !trapFlag_q)
    else $error("reset state wrong");
endmodule
`default_nettype wire

// ### break_cycle_pkg.sv
// constants and types for the break-cycle control block
package break_cycle_pkg;
  localparam int ADDR_W = 15;
  localparam int WORD_W = 18;
  localparam logic [14:0] CLOCK_ADDR = 15'h0007;
  localparam logic [14:0] PGM_ADDR   = 15'h0000;
  localparam logic [14:0] PGM_STEP   = 15'h0001;
  localparam logic [17:0] WORD_ZERO  = 18'h00000;
  localparam logic [17:0] WORD_ONE   = 18'h00001;
  localparam logic [14:0] ADDR_ZERO  = 15'h0000;
  localparam int IOT_CLR_AC_BIT = 14;
  localparam int IOT_P4_BIT     = 15;
  localparam int IOT_P2_BIT     = 16;
  localparam int IOT_P1_BIT     = 17;
  localparam int BUF_LINK_BIT   = 0;
  localparam int BUF_EXT_BIT    = 1;
  localparam int BUF_TRAP_BIT   = 2;
  // io-transfer subcommands controlling the clock, trap and interrupt enables
  localparam logic [2:0] IOT_CLK_ON   = 3'h1;
  localparam logic [2:0] IOT_CLK_OFF  = 3'h2;
  localparam logic [2:0] IOT_TRAP_ON  = 3'h3;
  localparam logic [2:0] IOT_INT_ON   = 3'h4;
  localparam logic [2:0] IOT_INT_OFF  = 3'h5;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_T1   = 8'h02,
    ST_T2   = 8'h04,
    ST_T3   = 8'h08,
    ST_T4   = 8'h10,
    ST_T5   = 8'h20,
    ST_T6   = 8'h40,
    ST_T7   = 8'h80
  } step_t;

  typedef enum logic [3:0] {
    BK_NONE  = 4'h1,
    BK_DATA  = 4'h2,
    BK_CLOCK = 4'h4,
    BK_PGM   = 4'h8
  } brk_t;
endpackage

// ### periph_model.sv
// fast peripheral that requests data breaks
`timescale 1ns/1ns
`default_nettype none
module periph_model (
  // clock, reset and bench control
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        devGo,
  input wire logic        devIn,
  input wire logic [14:0] devAddr,
  input wire logic [17:0] devWord,
  // processor side
  input wire logic        memWrite_q,
  input wire logic        bufferValid_q,
  input wire logic [17:0] memoryBuffer_q,
  output logic            dataReq,
  output logic            dataInward,
  output logic [14:0]     dataAddr,
  output logic [17:0]     dataOut,
  output logic [17:0]     got
);
  // request held with its address, word and direction until the write step (inward) or the buffer-valid step (outward)
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dataReq <= 1'b0;
    end else if (devGo) begin
      dataReq <= 1'b1;
    end else if (memWrite_q || bufferValid_q) begin
      dataReq <= 1'b0;
    end
  end
  // released lines change every cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      {dataInward, dataAddr, dataOut} <= '0;
    end else if (devGo) begin
      {dataInward, dataAddr, dataOut} <= {devIn, devAddr, devWord};
    end else if (!dataReq) begin
      {dataInward, dataAddr, dataOut} <= ~{dataInward, dataAddr, dataOut};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (bufferValid_q) begin
      got <= memoryBuffer_q;
    end
  end
endmodule
`default_nettype wire
